// *** hdl/gpio_bank_pkg.sv ***
package gpio_bank_pkg;

    // port numbering follows the pin groups, slot 7 is empty
    localparam int NPORT = 10;

    // register byte offsets
    localparam logic [11:0] DATA_BASE    = 12'h000;
    localparam logic [11:0] DIR_BASE     = 12'h040;
    localparam logic [11:0] PU_OFF       = 12'h080;
    localparam logic [11:0] LCD_DISPLAY_CTRL_REG_OFF     = 12'h084;
    localparam logic [11:0] BITOP_OFF    = 12'h088;
    localparam logic [11:0] IRQ_STAT_OFF = 12'h08c;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h090;

    // reset values
    localparam logic [7:0] DIR_RESET      = 8'hff;
    localparam logic [7:0] PU_RESET       = 8'h00;
    localparam logic [7:0] LCD_DISPLAY_CTRL_REG_RESET     = 8'h00;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h7;

    // bit-operation register fields
    localparam int BITOP_PORT_LSB = 0;
    localparam int BITOP_BIT_LSB  = 4;
    localparam int BITOP_VAL_POS  = 8;
    localparam int BITOP_DIR_POS  = 9;

    // lcd control: low nibble pairs of port 8, high nibble pairs of port 9
    localparam int LCD_PORT_A = 8;
    localparam int LCD_PORT_B = 9;

    // existing pins per port
    localparam logic [NPORT-1:0][7:0] PORT_MASK = {
        8'hff, 8'hfe, 8'h00, 8'h03, 8'h1f, 8'h1f, 8'hff, 8'hff, 8'h1f, 8'hff
    };
    localparam logic [NPORT-1:0] PORT_CAN_IN  = 10'h373;
    localparam logic [NPORT-1:0] PORT_CAN_OUT = 10'h37d;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } pin_drive_t;

endpackage

// *** hdl/gpio_port_bank.sv ***
`timescale 1ns/1ns
`default_nettype none

// How it works
// - every port with outputs writable per bit or byte
// - first port bidirectional with output latch
// - per-bit direction for first port
// - per-bit pull-up on first port inputs
// - reset puts first port in input
// - first three pins feed external interrupts
// - driven level change sets interrupt flag
// - second port five input-only pins
// - third and fourth ports output-only
// - fifth, sixth, seventh ports bidirectional per bit
// - last ports switch pairs to segments
module gpio_port_bank #(
    parameter int IRQ_LINES = 3
) (
    // clock and reset
    input  wire logic                                  clk_i,
    input  wire logic                                  resetn_i,
    // apb slave
    input  wire logic                                  psel_i,
    input  wire logic                                  penable_i,
    input  wire logic                                  pwrite_i,
    input  wire logic [11:0]                           paddr_i,
    input  wire logic [31:0]                           pwdata_i,
    input  wire logic [3:0]                            pstrb_i,
    output logic      [31:0]                           prdata_o,
    output logic                                       pready_o,
    output logic                                       pslverr_o,
    // pins
    input  wire logic [gpio_bank_pkg::NPORT-1:0][7:0]  pin_i,
    input  wire logic [1:0][7:0]                       lcd_seg_i,
    output gpio_bank_pkg::pin_drive_t [gpio_bank_pkg::NPORT-1:0] pin_drive_o,
    output logic      [7:0]                            pullup_o,
    // interrupts
    output logic      [IRQ_LINES-1:0]                  ext_irq_o,
    output logic                                       irq_o
);

    if (IRQ_LINES < 1 || IRQ_LINES > 8)
    begin : g_bad
        $error("gpio_port_bank: IRQ_LINES must be 1 to 8");
    end

    localparam int NP = gpio_bank_pkg::NPORT;

    // {hit, port index} for a per-port register group
    function automatic logic [4:0] port_of(input logic [11:0] a, input logic [11:0] base);
        logic [3:0] idx;
        logic       hit;
        idx = a[5:2];
        hit = (a[11:6] == base[11:6]) && (a[1:0] == 2'b00) && (idx < 4'(NP));
        if (hit)
            hit = (gpio_bank_pkg::PORT_MASK[idx] != 8'h00);
        return {hit, idx};
    endfunction

    // one control bit per pair of pins
    function automatic logic [7:0] pair_expand(input logic [3:0] b);
        return {b[3], b[3], b[2], b[2], b[1], b[1], b[0], b[0]};
    endfunction

    // per-port wiring
    logic [NP-1:0][7:0] lat_we, lat_wd, dir_we, dir_wd;
    logic [NP-1:0][7:0] alt_en, alt_val;
    logic [NP-1:0][7:0] dir_w, lvl_w, rd_w;

    for (genvar n = 0; n < NP; n++)
    begin : g_port
        port_slice #(
            .MASK    (gpio_bank_pkg::PORT_MASK[n]),
            .CAN_IN  (gpio_bank_pkg::PORT_CAN_IN[n]),
            .CAN_OUT (gpio_bank_pkg::PORT_CAN_OUT[n])
        ) u_slice (
            .clk_i     (clk_i),
            .resetn_i  (resetn_i),
            .lat_we_i  (lat_we[n]),
            .lat_wd_i  (lat_wd[n]),
            .dir_we_i  (dir_we[n]),
            .dir_wd_i  (dir_wd[n]),
            .alt_en_i  (alt_en[n]),
            .alt_val_i (alt_val[n]),
            .pin_i     (pin_i[n]),
            .drive_o   (pin_drive_o[n]),
            .dir_o     (dir_w[n]),
            .level_o   (lvl_w[n]),
            .rd_o      (rd_w[n])
        );
    end

    // control registers
    logic [7:0]           pu_q, pu_d;
    logic [7:0]           lcd_display_ctrl_reg_q, lcd_display_ctrl_reg_d;
    logic [IRQ_LINES-1:0] stat_q, stat_d;
    logic [IRQ_LINES-1:0] mask_q, mask_d;
    logic [IRQ_LINES-1:0] prev_q, prev_d;
    logic [IRQ_LINES-1:0] ext_q, ext_d;
    logic                 irq_q, irq_d;
    logic [7:0]           pullup_q, pullup_d;
    logic [31:0]          prdata_q, prdata_d;
    logic                 pready_q, pready_d;
    logic                 pslverr_q, pslverr_d;

    logic                 wr_acc;
    logic                 rd_setup;
    logic [4:0]           data_hit, dir_hit;
    logic [3:0]           bop_port;
    logic [2:0]           bop_bit;
    logic                 bop_val;
    logic                 bop_dir;
    logic                 bop_hit;
    logic                 mapped;
    logic [IRQ_LINES-1:0] ev;

    always_comb
    begin
        wr_acc   = psel_i & penable_i & pready_q & pwrite_i & pstrb_i[0];
        rd_setup = psel_i & ~penable_i;
        data_hit = port_of(paddr_i, gpio_bank_pkg::DATA_BASE);
        dir_hit  = port_of(paddr_i, gpio_bank_pkg::DIR_BASE);
        bop_port = pwdata_i[gpio_bank_pkg::BITOP_PORT_LSB +: 4];
        bop_bit  = pwdata_i[gpio_bank_pkg::BITOP_BIT_LSB +: 3];
        bop_val  = pwdata_i[gpio_bank_pkg::BITOP_VAL_POS];
        bop_dir  = pwdata_i[gpio_bank_pkg::BITOP_DIR_POS];
        bop_hit  = wr_acc && (paddr_i == gpio_bank_pkg::BITOP_OFF);
        mapped   = data_hit[4] || dir_hit[4]
                || (paddr_i == gpio_bank_pkg::PU_OFF) || (paddr_i == gpio_bank_pkg::LCD_DISPLAY_CTRL_REG_OFF)
                || (paddr_i == gpio_bank_pkg::BITOP_OFF) || (paddr_i == gpio_bank_pkg::IRQ_STAT_OFF)
                || (paddr_i == gpio_bank_pkg::IRQ_MASK_OFF);
    end

    // byte writes and single-bit writes to latches and directions
    always_comb
    begin
        for (int n = 0; n < NP; n++)
        begin
            lat_we[n] = 8'h00;
            lat_wd[n] = 8'h00;
            dir_we[n] = 8'h00;
            dir_wd[n] = 8'h00;
            if (wr_acc && data_hit[4] && data_hit[3:0] == 4'(n))
            begin
                lat_we[n] = 8'hff;
                lat_wd[n] = pwdata_i[7:0];
            end
            if (wr_acc && dir_hit[4] && dir_hit[3:0] == 4'(n))
            begin
                dir_we[n] = 8'hff;
                dir_wd[n] = pwdata_i[7:0];
            end
            if (bop_hit && bop_port == 4'(n))
            begin
                if (bop_dir)
                begin
                    dir_we[n] = 8'h01 << bop_bit;
                    dir_wd[n] = {8{bop_val}};
                end
                else
                begin
                    lat_we[n] = 8'h01 << bop_bit;
                    lat_wd[n] = {8{bop_val}};
                end
            end
        end
    end

    // segment takeover of pin pairs
    always_comb
    begin
        alt_en  = '0;
        alt_val = '0;
        alt_en[gpio_bank_pkg::LCD_PORT_A]  = pair_expand(lcd_display_ctrl_reg_q[3:0]);
        alt_en[gpio_bank_pkg::LCD_PORT_B]  = pair_expand(lcd_display_ctrl_reg_q[7:4]);
        alt_val[gpio_bank_pkg::LCD_PORT_A] = lcd_seg_i[0];
        alt_val[gpio_bank_pkg::LCD_PORT_B] = lcd_seg_i[1];
    end

    // control, interrupt and bus next state
    always_comb
    begin
        pu_d   = pu_q;
        lcd_display_ctrl_reg_d = lcd_display_ctrl_reg_q;
        mask_d = mask_q;
        if (wr_acc && paddr_i == gpio_bank_pkg::PU_OFF)
            pu_d = pwdata_i[7:0];
        if (wr_acc && paddr_i == gpio_bank_pkg::LCD_DISPLAY_CTRL_REG_OFF)
            lcd_display_ctrl_reg_d = pwdata_i[7:0];
        if (wr_acc && paddr_i == gpio_bank_pkg::IRQ_MASK_OFF)
            mask_d = pwdata_i[IRQ_LINES-1:0];
        // pull-up only on pins in input mode
        pullup_d = pu_d & ((dir_w[0] & ~dir_we[0]) | (dir_wd[0] & dir_we[0]));
        // any accepted level change, driven or external
        prev_d = lvl_w[0][IRQ_LINES-1:0];
        ev     = prev_q ^ prev_d;
        ext_d  = prev_d;
        stat_d = stat_q;
        if (wr_acc && paddr_i == gpio_bank_pkg::IRQ_STAT_OFF)
            stat_d = stat_q & ~pwdata_i[IRQ_LINES-1:0];
        stat_d = stat_d | ev;
        irq_d  = |(stat_d & ~mask_d);
        // answer in the access phase
        pready_d  = rd_setup;
        pslverr_d = rd_setup & ~mapped;
        prdata_d  = 32'h0000_0000;
        if (rd_setup && !pwrite_i)
        begin
            if (data_hit[4])
                prdata_d[7:0] = rd_w[data_hit[3:0]];
            else if (dir_hit[4])
                prdata_d[7:0] = dir_w[dir_hit[3:0]];
            else if (paddr_i == gpio_bank_pkg::PU_OFF)
                prdata_d[7:0] = pu_q;
            else if (paddr_i == gpio_bank_pkg::LCD_DISPLAY_CTRL_REG_OFF)
                prdata_d[7:0] = lcd_display_ctrl_reg_q;
            else if (paddr_i == gpio_bank_pkg::IRQ_STAT_OFF)
                prdata_d[IRQ_LINES-1:0] = stat_q;
            else if (paddr_i == gpio_bank_pkg::IRQ_MASK_OFF)
                prdata_d[IRQ_LINES-1:0] = mask_q;
            else
                prdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pu_q      <= gpio_bank_pkg::PU_RESET;
            lcd_display_ctrl_reg_q    <= gpio_bank_pkg::LCD_DISPLAY_CTRL_REG_RESET;
            mask_q    <= IRQ_LINES'(gpio_bank_pkg::IRQ_MASK_RESET);
            stat_q    <= '0;
            prev_q    <= '0;
            ext_q     <= '0;
            irq_q     <= 1'b0;
            pullup_q  <= 8'h00;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pu_q      <= pu_d;
            lcd_display_ctrl_reg_q    <= lcd_display_ctrl_reg_d;
            mask_q    <= mask_d;
            stat_q    <= stat_d;
            prev_q    <= prev_d;
            ext_q     <= ext_d;
            irq_q     <= irq_d;
            pullup_q  <= pullup_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
    assign pullup_o  = pullup_q;
    assign ext_irq_o = ext_q;
    assign irq_o     = irq_q;

    // checks
    logic wr_data0, wr_dir0, wr_pu, wr_bop0, rd_data0;
    assign wr_data0 = wr_acc && paddr_i == gpio_bank_pkg::DATA_BASE;
    assign wr_dir0  = wr_acc && paddr_i == gpio_bank_pkg::DIR_BASE;
    assign wr_pu    = wr_acc && paddr_i == gpio_bank_pkg::PU_OFF;
    assign wr_bop0  = bop_hit && bop_port == 4'h0 && !bop_dir;
    assign rd_data0 = rd_setup && !pwrite_i && paddr_i == gpio_bank_pkg::DATA_BASE;

    property p_dir_write;
        @(posedge clk_i) disable iff (!resetn_i)
        wr_dir0 |=> pin_drive_o[0].enable == ~$past(pwdata_i[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("port 0 direction not applied");

    property p_latch_write;
        @(posedge clk_i) disable iff (!resetn_i)
        wr_data0 |=> pin_drive_o[0].level == $past(pwdata_i[7:0]);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("port 0 latch not applied");

    property p_bit_write;
        @(posedge clk_i) disable iff (!resetn_i)
        wr_bop0 |=> pin_drive_o[0].level[$past(bop_bit)] == $past(bop_val);
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("single bit write lost");

    property p_reset_input;
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> pin_drive_o[0].enable == 8'h00 && pullup_o == 8'h00;
    endproperty
    a_reset_input: assert property (p_reset_input) else $error("port 0 not input after reset");

    property p_pullup;
        @(posedge clk_i) disable iff (!resetn_i)
        wr_pu && !wr_dir0 |=> pullup_o == ($past(pwdata_i[7:0]) & dir_w[0]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up on output pin");

    property p_level_flag;
        @(posedge clk_i) disable iff (!resetn_i)
        (lvl_w[0][0] != prev_q[0]) |=> stat_q[0] ##1 ext_irq_o[0] == $past(lvl_w[0][0], 2);
    endproperty
    a_level_flag: assert property (p_level_flag) else $error("level change did not set flag");

    property p_read_mux;
        @(posedge clk_i) disable iff (!resetn_i)
        rd_data0 |=> prdata_o == {24'h000000, $past(rd_w[0])} && pready_o;
    endproperty
    a_read_mux: assert property (p_read_mux) else $error("port 0 read value wrong");

    property p_input_only;
        @(posedge clk_i) disable iff (!resetn_i)
        pin_drive_o[1].enable == 8'h00 && pin_drive_o[6].enable[7:2] == 6'h00;
    endproperty
    a_input_only: assert property (p_input_only) else $error("missing pin driven");

    property p_output_only;
        @(posedge clk_i) disable iff (!resetn_i)
        $past(resetn_i) |-> pin_drive_o[2].enable == 8'hff && pin_drive_o[3].enable == 8'hff;
    endproperty
    a_output_only: assert property (p_output_only) else $error("output port not driving");

    property p_segment;
        @(posedge clk_i) disable iff (!resetn_i)
        lcd_display_ctrl_reg_q[4] |=> pin_drive_o[9].enable[1:0] == 2'b11;
    endproperty
    a_segment: assert property (p_segment) else $error("segment pair not taken over");

    c_bit_write:  cover property (@(posedge clk_i) disable iff (!resetn_i) wr_bop0);
    c_irq:        cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(irq_o));
    c_output_rd:  cover property (@(posedge clk_i) disable iff (!resetn_i) rd_data0 && dir_w[0] != 8'hff);
    c_bad_addr:   cover property (@(posedge clk_i) disable iff (!resetn_i) pslverr_o);

endmodule // gpio_port_bank

`default_nettype wire

// *** hdl/port_slice.sv ***
`timescale 1ns/1ns
`default_nettype none

module port_slice #(
    parameter logic [7:0] MASK    = 8'hff,
    parameter bit         CAN_IN  = 1'b1,
    parameter bit         CAN_OUT = 1'b1
) (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       resetn_i,
    // latch and direction writes
    input  wire logic [7:0]                 lat_we_i,
    input  wire logic [7:0]                 lat_wd_i,
    input  wire logic [7:0]                 dir_we_i,
    input  wire logic [7:0]                 dir_wd_i,
    // alternate output
    input  wire logic [7:0]                 alt_en_i,
    input  wire logic [7:0]                 alt_val_i,
    // pins
    input  wire logic [7:0]                 pin_i,
    output gpio_bank_pkg::pin_drive_t       drive_o,
    // state to the bank
    output logic      [7:0]                 dir_o,
    output logic      [7:0]                 level_o,
    output logic      [7:0]                 rd_o
);

    localparam logic [7:0] RST_DIR = CAN_IN ? (MASK & gpio_bank_pkg::DIR_RESET) : 8'h00;

    if (MASK != 8'h00 && !CAN_IN && !CAN_OUT)
    begin : g_bad
        $error("port_slice: pins need a direction");
    end

    logic [7:0]                lat_q, lat_d;
    logic [7:0]                dir_q, dir_d;
    logic [7:0]                s1_q, s2_q, s3_q;
    logic [7:0]                lvl_q, lvl_d;
    gpio_bank_pkg::pin_drive_t drv_q, drv_d;

    always_comb
    begin
        lat_d = CAN_OUT ? (((lat_q & ~lat_we_i) | (lat_wd_i & lat_we_i)) & MASK) : 8'h00;
        if (!CAN_OUT)
            dir_d = MASK;
        else if (!CAN_IN)
            dir_d = 8'h00;
        else
            dir_d = ((dir_q & ~dir_we_i) | (dir_wd_i & dir_we_i)) & MASK;
        // level accepted once stages two and three agree
        lvl_d = (lvl_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
        drv_d.enable = (alt_en_i | ~dir_d) & MASK;
        drv_d.level  = ((alt_en_i & alt_val_i) | (~alt_en_i & lat_d)) & MASK;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            lat_q <= 8'h00;
            dir_q <= RST_DIR;
            s1_q  <= 8'h00;
            s2_q  <= 8'h00;
            s3_q  <= 8'h00;
            lvl_q <= 8'h00;
            drv_q <= '0;
        end
        else
        begin
            lat_q <= lat_d;
            dir_q <= dir_d;
            s1_q  <= pin_i & MASK;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
            drv_q <= drv_d;
        end
    end

    assign drive_o = drv_q;
    assign dir_o   = dir_q;
    assign level_o = lvl_q;
    // input pins show the pin, output pins the latch
    assign rd_o    = ((lvl_q & dir_q) | (lat_q & ~dir_q)) & MASK;

endmodule // port_slice

`default_nettype wire

// *** sim/general_purpose_port_bank_test.sv ***
`timescale 1ns/1ns
`default_nettype none

module general_purpose_port_bank_test;
    logic                                   clk_i = 1'b0;
    logic                                   resetn_i = 1'b0;
    logic                                   psel_i = 1'b0;
    logic                                   penable_i = 1'b0;
    logic                                   pwrite_i = 1'b0;
    logic [11:0]                            paddr_i = '0;
    logic [31:0]                            pwdata_i = '0;
    logic [3:0]                             pstrb_i = 4'hf;
    logic [31:0]                            prdata_o;
    logic                                   pready_o;
    logic                                   pslverr_o;
    logic [9:0][7:0]                        pin_i;
    logic [9:0][7:0]                        ext = '0;
    logic [7:0]                             flt = '0;
    logic [1:0][7:0]                        lcd_seg_i = '0;
    gpio_bank_pkg::pin_drive_t [9:0]        pin_drive_o;
    logic [7:0]                             pullup_o;
    logic [2:0]                             ext_irq_o;
    logic                                   irq_o;
    int                                     n_fail = 0;
    int                                     n_compared = 0;
    int                                     lat[10];
    int                                     dir[10];
    int                                     ports[6] = '{0, 4, 5, 6, 8, 9};
    int                                     p, b, v, s;
    logic [31:0]                            rd;
    logic                                   err;

    always #10 clk_i = ~clk_i;

    gpio_port_bank uut (
        .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_i(pin_i),
        .lcd_seg_i(lcd_seg_i), .pin_drive_o(pin_drive_o), .pullup_o(pullup_o),
        .ext_irq_o(ext_irq_o), .irq_o(irq_o)
    );

    pad_model pads (
        .clk_i(clk_i), .drive_i(pin_drive_o), .pullup_i(pullup_o), .ext_i(ext),
        .float_i(flt), .pin_o(pin_i)
    );

    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            print_verdict();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    function automatic logic [11:0] da(input int q);
        return gpio_bank_pkg::DATA_BASE + 12'(4 * q);
    endfunction

    function automatic logic [11:0] dr(input int q);
        return gpio_bank_pkg::DIR_BASE + 12'(4 * q);
    endfunction

    task automatic pause(input int c);
        repeat (c) @(posedge clk_i);
    endtask

    initial
    begin
        pause(90000);
        n_fail++;
        print_verdict();
    end

    initial
    begin
        v = $urandom(32'hc9a1);
        pause(5);
        resetn_i <= 1'b1;
        foreach (ports[i])
        begin
            p = ports[i];
            apb(1'b0, dr(p), 0);
            chk("dir", gpio_bank_pkg::PORT_MASK[p], rd);
            chk("enable", 0, pin_drive_o[p].enable);
            lat[p] = 0;
        end
        chk("p2 enable", 8'hff, pin_drive_o[2].enable);
        chk("p3 enable", 8'hff, pin_drive_o[3].enable);
        apb(1'b0, gpio_bank_pkg::IRQ_MASK_OFF, 0);
        chk("mask", 3'h7, rd);
        $display("reset test done");
        repeat (4)
        begin
            foreach (ports[i])
            begin
                p = ports[i];
                lat[p] = $urandom & gpio_bank_pkg::PORT_MASK[p];
                dir[p] = $urandom & gpio_bank_pkg::PORT_MASK[p];
                ext[p] <= 8'($urandom);
                apb(1'b1, da(p), lat[p]);
                apb(1'b1, dr(p), dir[p]);
                pause(5);
                apb(1'b0, da(p), 0);
                chk("data", ((dir[p] & ext[p]) | (~dir[p] & lat[p])) & gpio_bank_pkg::PORT_MASK[p], rd);
                chk("enable", ~dir[p] & gpio_bank_pkg::PORT_MASK[p], pin_drive_o[p].enable);
                chk("level", lat[p] & ~dir[p], pin_drive_o[p].level & pin_drive_o[p].enable);
            end
        end
        foreach (ports[i])
        begin
            p = ports[i];
            do b = $urandom % 8; while (!gpio_bank_pkg::PORT_MASK[p][b]);
            v = $urandom % 4;
            apb(1'b1, gpio_bank_pkg::BITOP_OFF, p | (b << 4) | (v << 8));
            if (v[1]) dir[p] = v[0] ? dir[p] | (1 << b) : dir[p] & ~(1 << b);
            else lat[p] = v[0] ? lat[p] | (1 << b) : lat[p] & ~(1 << b);
            pause(1);
            chk("bit enable", ~dir[p] & gpio_bank_pkg::PORT_MASK[p], pin_drive_o[p].enable);
            chk("bit level", lat[p] & ~dir[p], pin_drive_o[p].level & pin_drive_o[p].enable);
        end
        $display("port access test done");
        apb(1'b1, dr(0), 8'h0f);
        apb(1'b1, gpio_bank_pkg::PU_OFF, 8'hff);
        flt <= 8'hff;
        pause(5);
        chk("pullup", 8'h0f, pullup_o);
        apb(1'b0, da(0), 0);
        chk("pulled data", 8'h0f | (lat[0] & 8'hf0), rd);
        flt <= 8'h00;
        apb(1'b1, gpio_bank_pkg::PU_OFF, 8'h00);
        ext[1] <= 8'($urandom);
        apb(1'b1, da(1), 8'($urandom));
        pause(5);
        apb(1'b0, da(1), 0);
        chk("input only", ext[1] & 8'h1f, rd);
        for (p = 2; p < 4; p++)
        begin
            lat[p] = $urandom & 8'hff;
            apb(1'b1, da(p), lat[p]);
            apb(1'b0, da(p), 0);
            chk("out data", lat[p], rd);
            chk("out level", lat[p], pin_drive_o[p].level);
        end
        apb(1'b0, da(7), 0);
        chk("unmapped err", 1'b1, err);
        chk("unmapped data", 0, rd);
        pstrb_i <= 4'he;
        apb(1'b1, da(2), ~lat[2]);
        pstrb_i <= 4'hf;
        pause(1);
        chk("strobe", lat[2], pin_drive_o[2].level);
        $display("port kinds test done");
        apb(1'b1, da(0), 0);
        apb(1'b1, dr(0), 8'hf8);
        pause(6);
        apb(1'b1, gpio_bank_pkg::IRQ_STAT_OFF, 3'h7);
        apb(1'b1, gpio_bank_pkg::IRQ_MASK_OFF, 3'h6);
        apb(1'b1, da(0), 8'h01);
        pause(6);
        chk("ext irq", 3'h1, ext_irq_o);
        chk("irq", 1'b1, irq_o);
        apb(1'b0, gpio_bank_pkg::IRQ_STAT_OFF, 0);
        chk("status", 3'h1, rd);
        apb(1'b1, gpio_bank_pkg::IRQ_STAT_OFF, 3'h1);
        pause(1);
        chk("irq cleared", 1'b0, irq_o);
        apb(1'b1, gpio_bank_pkg::IRQ_MASK_OFF, 3'h7);
        apb(1'b1, da(0), 8'h03);
        pause(6);
        apb(1'b0, gpio_bank_pkg::IRQ_STAT_OFF, 0);
        chk("masked status", 3'h2, rd);
        chk("masked irq", 1'b0, irq_o);
        apb(1'b1, dr(0), 8'hff);
        pause(6);
        apb(1'b1, gpio_bank_pkg::IRQ_STAT_OFF, 3'h7);
        apb(1'b1, gpio_bank_pkg::IRQ_MASK_OFF, 3'h0);
        ext[0] <= ext[0] ^ 8'h04;
        pause(6);
        apb(1'b0, gpio_bank_pkg::IRQ_STAT_OFF, 0);
        chk("input status", 3'h4, rd);
        chk("input irq", 1'b1, irq_o);
        $display("interrupt test done");
        v = $urandom & 8'hff;
        lcd_seg_i <= 16'($urandom);
        apb(1'b1, gpio_bank_pkg::LCD_DISPLAY_CTRL_REG_OFF, v);
        pause(2);
        for (p = 0; p < 2; p++)
        begin
            s = 0;
            for (b = 0; b < 4; b++)
                if (v[4 * p + b]) s = s | (3 << (2 * b));
            s = s & gpio_bank_pkg::PORT_MASK[8 + p];
            chk("seg enable", s, pin_drive_o[8 + p].enable & s);
            chk("seg level", lcd_seg_i[p] & s, pin_drive_o[8 + p].level & s);
        end
        apb(1'b1, gpio_bank_pkg::LCD_DISPLAY_CTRL_REG_OFF, 0);
        $display("segment test done");
        print_verdict();
    end
endmodule // general_purpose_port_bank_test

`default_nettype wire

// *** sim/pad_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module pad_model (
    // clock
    input  wire logic                                    clk_i,
    // device side
    input  wire gpio_bank_pkg::pin_drive_t [9:0]         drive_i,
    input  wire logic [7:0]                              pullup_i,
    // board side
    input  wire logic [9:0][7:0]                         ext_i,
    input  wire logic [7:0]                              float_i,
    output logic      [9:0][7:0]                         pin_o
);
    logic [7:0] wiggle_q = 8'h55;

    // an open pin without pull-up shows no stable level
    always_ff @(posedge clk_i)
    begin
        wiggle_q <= ~wiggle_q;
    end

    always_comb
    begin
        for (int p = 0; p < 10; p++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                if (drive_i[p].enable[b])
                    pin_o[p][b] = drive_i[p].level[b];
                else if (p == 0 && float_i[b])
                    pin_o[p][b] = pullup_i[b] | wiggle_q[b];
                else
                    pin_o[p][b] = ext_i[p][b];
            end
        end
    end
endmodule // pad_model

`default_nettype wire
